/* File: common/ssp_pkg.sv */
// package for the buffered synchronous serial port
package ssp_pkg;
    // register offsets
    localparam logic [7:0] ADDR_CTRL_ONE   = 8'h26;
    localparam logic [7:0] ADDR_CTRL_TWO   = 8'h27;
    localparam logic [7:0] ADDR_STATUS     = 8'h27;
    localparam logic [7:0] ADDR_BUF_FIRST  = 8'h28;
    localparam logic [7:0] ADDR_BUF_LAST   = 8'h2f;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h31;
    localparam logic [7:0] ADDR_PRESCALER  = 8'h32;
    // control one fields and reset value
    localparam int         BIT_RUN         = 7;
    localparam int         BIT_ABORT       = 6;
    localparam int         MODE_LSB        = 3;
    localparam int         CLKSEL_LSB      = 0;
    localparam logic [7:0] CTRL_ONE_RESET  = 8'h00;
    // control two fields
    localparam int         WAIT_LSB        = 3;
    localparam int         COUNT_LSB       = 0;
    localparam logic [4:0] CTRL_TWO_RESET  = 5'h00;
    // status bit positions
    localparam int         BIT_ACTIVE      = 7;
    localparam int         BIT_SHIFTING    = 6;
    // mode codes
    localparam logic [2:0] MODE_TX8        = 3'h0;
    localparam logic [2:0] MODE_TX4        = 3'h2;
    localparam logic [2:0] MODE_DUPLEX8    = 3'h4;
    localparam logic [2:0] MODE_RX8        = 3'h5;
    localparam logic [2:0] MODE_RX4        = 3'h6;
    // clock select codes
    localparam logic [2:0] CLK_SLOWEST     = 3'h0;
    localparam logic [2:0] CLK_RESERVED    = 3'h6;
    localparam logic [2:0] CLK_EXTERNAL    = 3'h7;
    // divider exponents (half period = 2^(n-1) of the source; the fast one gives 2^(n-1-clksel))
    localparam int         DIV_SLOW_EXP    = 13;
    localparam int         DIV_LOWF_EXP    = 5;
    localparam int         DIV_FAST_EXP    = 9;
    localparam int         DEPTH           = 8;

    typedef enum logic [1:0] {
        SSP_IDLE, SSP_SHIFT, SSP_GAP
    } ssp_state_e;

    typedef struct packed {
        logic       run;
        logic       abort;
        logic [2:0] mode;
        logic [2:0] clksel;
    } ssp_ctrl_one_s;

    typedef struct packed {
        logic [1:0] wait_sel;
        logic [2:0] count;
    } ssp_ctrl_two_s;
endpackage

/* File: verilog/ssp_clkgen.sv */
// serial clock divider for the buffered serial port
`timescale 1ns/1ps
module ssp_clkgen #(
    parameter int CNT_W = 13
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // control
    input  wire logic       enable,
    input  wire logic [2:0] clksel,
    input  wire logic       low_tap,
    input  wire logic       low_freq_tick,
    // half-period tick
    output logic            half_tick
);
    initial begin
        if (CNT_W < ssp_pkg::DIV_SLOW_EXP) begin
            $error("ssp_clkgen: counter too narrow");
        end
    end

    logic [CNT_W-1:0] cnt;
    logic             use_low;
    logic [CNT_W-1:0] top;
    logic             step;

    // low tap counts low-frequency ticks, otherwise every clock
    assign use_low = (clksel == ssp_pkg::CLK_SLOWEST) && low_tap; // RQ9
    assign step    = use_low ? low_freq_tick : 1'b1;
    assign top     = use_low ?
        CNT_W'((1 << (ssp_pkg::DIV_LOWF_EXP - 1)) - 1) :
        (clksel == ssp_pkg::CLK_SLOWEST) ?
        CNT_W'((1 << (ssp_pkg::DIV_SLOW_EXP - 1)) - 1) :
        CNT_W'((1 << (ssp_pkg::DIV_FAST_EXP - 1 - 32'(clksel))) - 1); // RQ9
    assign half_tick = enable && step && (cnt >= top);

    // free divider, held clear while disabled
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= '0;
        end else if (!enable || half_tick) begin
            cnt <= '0;
        end else if (step) begin
            cnt <= cnt + CNT_W'(1);
        end
    end
endmodule

/* File: verilog/ssp_port.sv */
// buffered clocked-synchronous serial port, device side
//
// How it works
// (RQ1) An eight-entry buffer holds words so up to 64 bits shift without help.
// (RQ2) One run moves the programmed number of words back to back.
// (RQ3) The eight entries sit at consecutive addresses 0x28 to 0x2f.
// (RQ4) Finishing the count raises done: empty for transmit, full otherwise.
// (RQ5) Internal clock 8-bit receive or duplex waits 0,1,3 or 7 word times.
// (RQ6) Writing run 1 starts a transfer and writing it 0 stops it; a 0 written in the wait between words is ignored.
// (RQ7) Abort 1 kills the transfer and clears itself; 0 lets it go on.
// (RQ8) Mode codes: 000 tx8, 010 tx4, 100 duplex8, 101 rx8, 110 rx4.
// (RQ9) Clock select picks a divided clock, low tap, or the external pin.
// (RQ10) Reset clears control one to all zeros.
// (RQ11) Software stops and aborts before changing mode or clock.
// (RQ12) Control one is write-only and reads back as zero.
// (RQ13) Data goes out on the falling edge and is sampled on the rising edge.
// (RQ14) Words go lsb first; 4-bit modes use the low nibble, receive zeros top.
// (RQ15) Count 000 is one word up to 111 as eight, from the lowest entry.
// (RQ16) Active flag drops when the current word ends after stop, or at abort.
// (RQ17) One done event per operation; the count setting is kept.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module ssp_port #(
    parameter int DEPTH = ssp_pkg::DEPTH
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    // system state
    input  wire logic       low_freq_tick,
    input  wire logic       low_power_halt_state,
    // serial pins, clock pin split into in, out and enable
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe_n,
    output logic            so,
    input  wire logic       si,
    // interrupt
    output logic            transfer_done_irq
);
    initial begin
        if (DEPTH != ssp_pkg::DEPTH) begin
            $error("ssp_port: buffer depth must be eight");
        end
    end

    ssp_pkg::ssp_ctrl_one_s ctrl;
    ssp_pkg::ssp_ctrl_two_s ctrl2;
    ssp_pkg::ssp_state_e    state;
    logic [7:0]             buffer [DEPTH];
    logic [2:0]             word_idx;
    logic [2:0]             bit_idx;
    logic [6:0]             gap_cnt;
    logic [7:0]             shreg;
    logic                   sck_lvl;
    logic                   sck_q;
    logic                   stop_req;
    logic                   irq_status;
    logic                   irq_mask;
    logic                   prescaler_tap_select;
    logic                   half_tick;

    // address decode
    wire sel_c1  = (addr == ssp_pkg::ADDR_CTRL_ONE);
    wire sel_c2  = (addr == ssp_pkg::ADDR_CTRL_TWO);
    wire sel_buf = (addr >= ssp_pkg::ADDR_BUF_FIRST) &&
                   (addr <= ssp_pkg::ADDR_BUF_LAST); // RQ3
    wire sel_ist = (addr == ssp_pkg::ADDR_IRQ_STATUS);
    wire sel_msk = (addr == ssp_pkg::ADDR_IRQ_MASK);
    wire sel_pre = (addr == ssp_pkg::ADDR_PRESCALER);
    wire [2:0] buf_idx = addr[2:0];

    // mode decode
    wire m_tx   = (ctrl.mode == ssp_pkg::MODE_TX8) ||
                  (ctrl.mode == ssp_pkg::MODE_TX4); // RQ8
    wire m_rx   = (ctrl.mode == ssp_pkg::MODE_RX8) ||
                  (ctrl.mode == ssp_pkg::MODE_RX4) ||
                  (ctrl.mode == ssp_pkg::MODE_DUPLEX8); // RQ8
    wire m_nib  = (ctrl.mode == ssp_pkg::MODE_TX4) ||
                  (ctrl.mode == ssp_pkg::MODE_RX4); // RQ14
    wire m_ok   = m_tx || m_rx;
    wire ext    = (ctrl.clksel == ssp_pkg::CLK_EXTERNAL); // RQ9
    wire clk_ok = (ctrl.clksel != ssp_pkg::CLK_RESERVED) &&
                  (ext || !low_power_halt_state ||
                   ctrl.clksel == ssp_pkg::CLK_SLOWEST);
    wire use_wait = !ext && (ctrl.mode == ssp_pkg::MODE_RX8 ||
                             ctrl.mode == ssp_pkg::MODE_DUPLEX8); // RQ5
    wire low_tap  = prescaler_tap_select || low_power_halt_state;
    wire [2:0] last_bit = m_nib ? 3'h3 : 3'h7; // RQ14

    // shift edges: internal level or pin after a one-cycle register
    wire fall = ext ? (sck_q && !sck_in) : (half_tick && sck_lvl);
    wire rise = ext ? (!sck_q && sck_in) : (half_tick && !sck_lvl);
    wire shifting  = (state == ssp_pkg::SSP_SHIFT);
    wire last_word = (word_idx == ctrl2.count); // RQ15
    wire word_end  = shifting && rise && (bit_idx == last_bit);
    wire op_done   = word_end && last_word; // RQ17
    wire abort_w   = wr && sel_c1 && wdata[ssp_pkg::BIT_ABORT];
    wire start_w   = wr && sel_c1 && wdata[ssp_pkg::BIT_RUN] &&
                     !wdata[ssp_pkg::BIT_ABORT];
    wire active    = (state != ssp_pkg::SSP_IDLE);
    wire [7:0] rx_word = m_nib ? {4'h0, si, shreg[3:1]} :
                                 {si, shreg[7:1]}; // RQ14
    wire [3:0] gap_len = 4'((4'h1 << ctrl2.wait_sel) - 4'h1); // RQ5

    ssp_clkgen #(
        .CNT_W         (ssp_pkg::DIV_SLOW_EXP)
    ) u_clkgen (
        .clock         (clock),
        .sys_rst       (sys_rst),
        .enable        ((shifting || state == ssp_pkg::SSP_GAP) && !ext),
        .clksel        (ctrl.clksel),
        .low_tap       (low_tap),
        .low_freq_tick (low_freq_tick),
        .half_tick     (half_tick)
    );

    // control registers, abort never stored as it self-clears
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl                 <= ssp_pkg::ssp_ctrl_one_s'(
                                    ssp_pkg::CTRL_ONE_RESET); // RQ10
            ctrl2                <= ssp_pkg::ssp_ctrl_two_s'(
                                    ssp_pkg::CTRL_TWO_RESET);
            irq_mask             <= 1'b0;
            prescaler_tap_select <= 1'b0;
        end else if (wr) begin
            if (sel_c1) begin
                ctrl       <= ssp_pkg::ssp_ctrl_one_s'(wdata); // RQ6
                ctrl.abort <= 1'b0; // RQ7
            end else if (sel_c2) begin
                ctrl2 <= ssp_pkg::ssp_ctrl_two_s'(wdata[4:0]);
            end else if (sel_msk) begin
                irq_mask <= wdata[0];
            end else if (sel_pre) begin
                prescaler_tap_select <= wdata[0];
            end
        end
    end

    // transfer sequencer
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= ssp_pkg::SSP_IDLE;
            word_idx <= 3'h0;
            bit_idx  <= 3'h0;
            gap_cnt  <= 7'h00;
            stop_req <= 1'b0;
        end else if (abort_w) begin
            state    <= ssp_pkg::SSP_IDLE; // RQ16
            stop_req <= 1'b0;
        end else begin
            case (state)
                ssp_pkg::SSP_IDLE: begin
                    if (start_w && m_ok && clk_ok) begin
                        state    <= ssp_pkg::SSP_SHIFT; // RQ6
                        word_idx <= 3'h0; // RQ15
                        bit_idx  <= 3'h0;
                        stop_req <= 1'b0;
                    end
                end
                ssp_pkg::SSP_SHIFT: begin
                    if (wr && sel_c1 && !wdata[ssp_pkg::BIT_RUN]) begin
                        stop_req <= 1'b1; // RQ6
                    end
                    if (rise) begin
                        bit_idx <= bit_idx + 3'h1;
                    end
                    if (word_end) begin
                        bit_idx  <= 3'h0;
                        word_idx <= word_idx + 3'h1; // RQ2
                        gap_cnt  <= {gap_len[2:0], 4'h0}; // 16 halves a word
                        if (last_word || stop_req) begin
                            state <= ssp_pkg::SSP_IDLE; // RQ16
                        end else if (use_wait && gap_len != 4'h0) begin
                            state <= ssp_pkg::SSP_GAP; // RQ5
                        end
                    end
                end
                default: begin
                    // wait counts half periods, pin held high meanwhile
                    if (half_tick) begin
                        gap_cnt <= gap_cnt - 7'h01;
                        if (gap_cnt == 7'h01) begin
                            state <= ssp_pkg::SSP_SHIFT; // RQ5
                        end
                    end
                end
            endcase
        end
    end

    // clock level, shift register and serial output
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sck_lvl <= 1'b1;
            sck_q   <= 1'b1;
            shreg   <= 8'h00;
            so      <= 1'b1;
        end else begin
            sck_q <= sck_in;
            // idle high, and frozen high through the wait between words
            if (!shifting) begin
                sck_lvl <= 1'b1; // RQ5
            end else if (half_tick) begin
                sck_lvl <= !sck_lvl;
            end
            if (shifting && fall) begin
                // load at word start, else move toward lsb
                if (bit_idx == 3'h0) begin
                    so    <= buffer[word_idx][0]; // RQ13
                    shreg <= buffer[word_idx];
                end else if (m_rx) begin
                    // receive and duplex: the rising edge already moved the word
                    so <= shreg[0]; // RQ14
                end else begin
                    so    <= shreg[1]; // RQ14
                    shreg <= {1'b0, shreg[7:1]};
                end
            end else if (shifting && rise && m_rx) begin
                shreg <= rx_word;
            end
        end
    end

    // buffer entries: software writes, receive stores whole words
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_buf
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    buffer[gi] <= 8'h00;
                end else if (word_end && m_rx &&
                             word_idx == 3'(gi)) begin
                    buffer[gi] <= rx_word; // RQ1
                end else if (wr && sel_buf && buf_idx == 3'(gi)) begin
                    buffer[gi] <= wdata;
                end
            end
        end
    endgenerate

    // sticky done flag, set wins over write-one-to-clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= 1'b0;
        end else if (op_done) begin
            irq_status <= 1'b1; // RQ4
        end else if (wr && sel_ist && wdata[0]) begin
            irq_status <= 1'b0;
        end
    end

    // read data one cycle after strobe; control one reads as zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata <= 8'h00;
        end else if (!rd) begin
            rdata <= 8'h00;
        end else if (sel_buf) begin
            rdata <= buffer[buf_idx];
        end else if (sel_ist) begin
            rdata <= {7'h00, irq_status};
        end else if (sel_msk) begin
            rdata <= {7'h00, irq_mask};
        end else if (sel_pre) begin
            rdata <= {7'h00, prescaler_tap_select};
        end else if (sel_c2) begin
            rdata <= {active, shifting, 6'h00}; // RQ16
        end else begin
            rdata <= 8'h00; // RQ12
        end
    end

    // pins and interrupt
    assign sck_out  = sck_lvl;
    assign sck_oe_n = ext || !active;
    assign transfer_done_irq = irq_status && irq_mask;

    a_done_irq_sets: assert property ( // RQ4
        @(posedge clock) disable iff (sys_rst)
        op_done |=> irq_status) else $error("done flag not set");
    a_abort_stops: assert property ( // RQ7
        @(posedge clock) disable iff (sys_rst)
        abort_w |=> !active) else $error("abort left active");
    a_reserved_idle: assert property ( // RQ8
        @(posedge clock) disable iff (sys_rst)
        (start_w && !m_ok && !active) |=> !active)
        else $error("reserved mode started");
    a_start_runs: assert property ( // RQ6
        @(posedge clock) disable iff (sys_rst)
        (start_w && m_ok && clk_ok && !active) |=> shifting)
        else $error("start ignored");
    a_count_kept: assert property ( // RQ17
        @(posedge clock) disable iff (sys_rst)
        op_done |=> $stable(ctrl2.count)) else $error("count lost");
    a_nibble_zero: assert property ( // RQ14
        @(posedge clock) disable iff (sys_rst)
        (word_end && m_rx && m_nib) |=> buffer[$past(word_idx)][7:4] == 4'h0)
        else $error("nibble top not zero");
    a_stop_ends: assert property ( // RQ16
        @(posedge clock) disable iff (sys_rst)
        (word_end && stop_req) |=> !active) else $error("stop late");
    a_word_first: assert property ( // RQ15
        @(posedge clock) disable iff (sys_rst)
        (!active ##1 active) |-> word_idx == 3'h0)
        else $error("not lowest entry first");
    a_gap_pin_high: assert property ( // RQ5
        @(posedge clock) disable iff (sys_rst)
        (state == ssp_pkg::SSP_GAP) |-> sck_out)
        else $error("clock ran in wait");
endmodule

/* File: test/ssp_peer.sv */
// behavioural model of the external serial peripheral
`timescale 1ns/1ps
module ssp_peer (
    // clock and bench control
    input  wire logic       clock,
    input  wire logic       clr,
    input  wire logic [3:0] width,
    // serial pins
    input  wire logic       sck,
    input  wire logic       so,
    output logic            si,
    output logic            ext_sck
);
    logic [7:0] tx_mem [8];
    logic [7:0] rx_mem [8];
    logic [7:0] bi;
    logic [7:0] wi;
    logic [7:0] pos;

    // word and bit position from the running bit count
    assign wi  = bi / 8'(width);
    assign pos = bi % 8'(width);

    initial begin
        si      = 1'b0;
        ext_sck = 1'b1;
    end

    // next bit goes out on the falling edge, lsb first
    always @(negedge sck) begin
        si <= tx_mem[wi[2:0]][pos[2:0]];
    end

    // capture on the rising edge; clear keeps upper bits zero in 4-bit use
    always @(posedge sck or posedge clr) begin
        if (clr) begin
            bi <= 8'h00;
            for (int i = 0; i < 8; i++) rx_mem[i] <= 8'h00;
        end else begin
            rx_mem[wi[2:0]][pos[2:0]] <= so;
            bi <= bi + 8'h01;
        end
    end

    // external clock only runs within a frame, idles high otherwise
    task automatic clock_bits(input int n, input int half);
        repeat (n) begin
            repeat (half) @(posedge clock);
            ext_sck <= 1'b0;
            repeat (half) @(posedge clock);
            ext_sck <= 1'b1;
        end
    endtask
endmodule

/* File: test/tb_ssp_port.sv */
// self-checking bench for the buffered serial port
`timescale 1ns/1ps
module tb_ssp_port;
    logic       clock;
    logic       sys_rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       low_freq_tick;
    logic       halt;
    logic       sck_out;
    logic       sck_oe_n;
    logic       so;
    logic       si;
    logic       ext_sck;
    logic       sck_in;
    logic       transfer_done_irq;
    logic       clr;
    logic [3:0] width;
    logic [1:0] tick_cnt;
    logic [7:0] rv;
    int         miscompares;
    int         num_checks;

    // pin level: device drives when enabled, else peer or pull-up
    assign sck_in = sck_oe_n ? ext_sck : sck_out;

    ssp_port DUT (
        .clock(clock), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .low_freq_tick(low_freq_tick),
        .low_power_halt_state(halt), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .so(so), .si(si),
        .transfer_done_irq(transfer_done_irq)
    );

    ssp_peer PEER (
        .clock(clock), .clr(clr), .width(width), .sck(sck_in), .so(so),
        .si(si), .ext_sck(ext_sck)
    );

    always #5 clock = ~clock;

    // low-frequency source, one tick every four clocks
    always @(posedge clock) begin
        tick_cnt      <= tick_cnt + 2'h1;
        low_freq_tick <= (tick_cnt == 2'h3);
    end

    task automatic check(input string nm, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic irq_after_edge(input logic exp);
        @(posedge clock);
        #1 check("irq", {7'h00, transfer_done_irq}, {7'h00, exp});
    endtask

    // word times of one operation: words plus the waits between them
    function automatic int frame_words(input int n, input int g);
        return n + (n - 1) * g;
    endfunction

    // one whole operation: program, load, start, wait, compare both sides
    task automatic xfer(input logic [2:0] m, ck, cnt, input logic wr2);
        int         n;
        int         w;
        logic [7:0] msk;
        logic [7:0] tx [8];
        logic [7:0] pr [8];
        int         cyc;
        int         g;
        logic [1:0] wt;
        n   = int'(cnt) + 1;
        w   = (m == ssp_pkg::MODE_TX4 || m == ssp_pkg::MODE_RX4) ? 4 : 8;
        msk = (w == 4) ? 8'h0f : 8'hff;
        // random wait only where it applies: 8-bit rx or duplex, own clock
        wt  = 2'h0;
        if (wr2 && ck != ssp_pkg::CLK_EXTERNAL &&
            (m == ssp_pkg::MODE_RX8 || m == ssp_pkg::MODE_DUPLEX8))
            wt = 2'($urandom);
        g   = (1 << wt) - 1;
        width <= 4'(w);
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b01, m, ck});
        if (wr2) wr_reg(ssp_pkg::ADDR_CTRL_TWO, {3'h0, wt, cnt});
        for (int i = 0; i < 8; i++) begin
            tx[i] = 8'($urandom);
            pr[i] = 8'($urandom);
            PEER.tx_mem[i] = pr[i];
            wr_reg(ssp_pkg::ADDR_BUF_FIRST + 8'(i), tx[i]);
        end
        wr_reg(ssp_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr_reg(ssp_pkg::ADDR_IRQ_MASK, 8'h01);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b10, m, ck});
        if (ck == ssp_pkg::CLK_EXTERNAL) PEER.clock_bits(n * w, 20);
        for (cyc = 0; cyc < 20000 && transfer_done_irq !== 1'b1; cyc++)
            @(posedge clock);
        #1 check("done", {7'h00, transfer_done_irq}, 8'h01);
        check("bits", PEER.bi, 8'(n * w));
        // code 5: eight clocks a half period, two halves a bit
        if (ck == 3'h5)
            check("frame", 8'(cyc / (16 * w)), 8'(frame_words(n, g)));
        for (int i = 0; i < n; i++) begin
            if (m != ssp_pkg::MODE_RX8 && m != ssp_pkg::MODE_RX4)
                check("sent", PEER.rx_mem[i], tx[i] & msk);
            if (m[2]) begin
                rd_reg(ssp_pkg::ADDR_BUF_FIRST + 8'(i), rv);
                check("recv", rv, pr[i] & msk);
            end
        end
        // masked status stays sticky until a one is written back
        wr_reg(ssp_pkg::ADDR_IRQ_MASK, 8'h00);
        irq_after_edge(1'b0);
        rd_reg(ssp_pkg::ADDR_IRQ_STATUS, rv);
        check("sticky", rv & 8'h01, 8'h01);
        wr_reg(ssp_pkg::ADDR_IRQ_STATUS, 8'h01);
        wr_reg(ssp_pkg::ADDR_IRQ_MASK, 8'h01);
        irq_after_edge(1'b0);
        $display("test mode %h clock %h words %0d done", m, ck, n);
    endtask

    initial begin
        #600_000;
        miscompares++;
        $display("watchdog expired");
        end_sim;
    end

    initial begin
        logic [2:0] modes [5];
        modes = '{ssp_pkg::MODE_TX8, ssp_pkg::MODE_TX4,
                  ssp_pkg::MODE_DUPLEX8, ssp_pkg::MODE_RX8,
                  ssp_pkg::MODE_RX4};
        clock = 1'b0;
        sys_rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        clr = 1'b0;
        width = 4'h8;
        halt = 1'b0;
        tick_cnt = 2'h0;
        low_freq_tick = 1'b0;
        miscompares = 0;
        num_checks = 0;
        void'($urandom(76835));
        repeat (4) @(posedge clock);
        sys_rst <= 1'b0;
        #1 check("idle", {4'h0, so, sck_out, sck_oe_n,
                          transfer_done_irq}, 8'h0e);
        rd_reg(ssp_pkg::ADDR_CTRL_ONE, rv);
        check("ctrl one", rv, 8'h00);
        rd_reg(8'h40, rv);
        check("unmapped", rv, 8'h00);
        rd_reg(ssp_pkg::ADDR_STATUS, rv);
        check("status", rv, 8'h00);
        $display("test reset done");
        for (int k = 0; k < 5; k++)
            xfer(modes[k], 3'h5, 3'($urandom_range(7)), 1'b1);
        xfer(ssp_pkg::MODE_DUPLEX8, ssp_pkg::CLK_EXTERNAL, 3'h7, 1'b1);
        xfer(ssp_pkg::MODE_TX4, 3'h5, 3'h7, 1'b0);
        wr_reg(ssp_pkg::ADDR_PRESCALER, 8'h01);
        xfer(ssp_pkg::MODE_TX8, ssp_pkg::CLK_SLOWEST, 3'h0, 1'b1);
        wr_reg(ssp_pkg::ADDR_PRESCALER, 8'h00);
        xfer(ssp_pkg::MODE_RX8, 3'h1, 3'h0, 1'b1);
        // run cleared in mid-word: that word ends, then the port idles
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b01, ssp_pkg::MODE_TX8, 3'h5});
        wr_reg(ssp_pkg::ADDR_CTRL_TWO, 8'h03);
        clr <= 1'b1;
        @(posedge clock);
        clr <= 1'b0;
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b10, ssp_pkg::MODE_TX8, 3'h5});
        repeat (50) @(posedge clock);
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b00, ssp_pkg::MODE_TX8, 3'h5});
        repeat (200) @(posedge clock);
        rd_reg(ssp_pkg::ADDR_STATUS, rv);
        check("stopped", rv, 8'h00);
        check("one word", PEER.bi, 8'h08);
        check("no done", {7'h00, transfer_done_irq}, 8'h00);
        // abort in mid-word drops the active flag at once
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b10, ssp_pkg::MODE_TX8, 3'h5});
        repeat (50) @(posedge clock);
        rd_reg(ssp_pkg::ADDR_STATUS, rv);
        check("active", rv & 8'hc0, 8'hc0);
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b01, ssp_pkg::MODE_TX8, 3'h5});
        rd_reg(ssp_pkg::ADDR_STATUS, rv);
        check("aborted", rv & 8'h80, 8'h00);
        check("released", {7'h00, sck_oe_n}, 8'h01);
        // reserved mode code must not start anything
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b01, 3'h1, 3'h5});
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b10, 3'h1, 3'h5});
        repeat (40) @(posedge clock);
        rd_reg(ssp_pkg::ADDR_STATUS, rv);
        check("reserved", rv & 8'h80, 8'h00);
        // a fast divided clock is refused while halted
        halt <= 1'b1;
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b01, ssp_pkg::MODE_TX8, 3'h5});
        wr_reg(ssp_pkg::ADDR_CTRL_ONE, {2'b10, ssp_pkg::MODE_TX8, 3'h5});
        rd_reg(ssp_pkg::ADDR_STATUS, rv);
        check("halt refuse", rv, 8'h00);
        halt <= 1'b0;
        $display("test abort and reserved done");
        end_sim;
    end
endmodule
